// ==== bench/faps_flash_model.sv ====
// Behavioural flash device facing the host sequencer.
// Assumes the bench resolves the shared data wire and feeds it back here.
module faps_flash_model #(
  parameter logic [7:0] PROG_CODE     = 8'h01,
  parameter logic [7:0] ERASE_CODE    = 8'h02,
  parameter logic [7:0] ERASE_CONFIRM = 8'h03
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        vpp_hi,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  dq_wire,
  input  wire logic        hang,
  input  wire logic [15:0] busy_cyc,
  output logic      [7:0]  dq_drv,
  output logic             dq_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Array and state
  // ----------------------------------------
  logic [7:0]  mem [0:255];
  logic [1:0]  phase_r;
  logic        busy_r, ers_r, tog_r, we_q, oe_q, ce_q, vpp_q;
  logic [15:0] left_r;
  logic [7:0]  wa_r, wd_r;
  logic [5:0]  flt_r;
  int          vpp_err, wr_err;

  // Blank array at power-up
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'hff;
    flt_r = 6'h0;
    vpp_err = 0;
    wr_err = 0;
  end

  // Pin watcher and self-timed algorithm
  always @(posedge ref_clk) begin
    {we_q, oe_q, ce_q, vpp_q} <= {we_n, oe_n, ce_n, vpp_hi};
    flt_r <= flt_r + 6'h1;
    // supply moves only with both selects high
    if (!rst && vpp_hi !== vpp_q && !(ce_n && oe_n && ce_q && oe_q)) vpp_err <= vpp_err + 1;
    if (rst) begin
      phase_r <= 2'd0;
      busy_r <= 1'b0;
      tog_r <= 1'b0;
    end else begin
      // toggle flips once per read while busy
      if (busy_r && oe_q && !oe_n && !ce_n) tog_r <= ~tog_r;
      if (busy_r && !hang) begin
        left_r <= left_r - 16'h1;
        if (left_r == 16'h0) begin
          busy_r <= 1'b0;
          // one byte, or the whole array
          if (ers_r) for (int i = 0; i < 256; i++) mem[i] <= 8'hff;
          else mem[wa_r] <= wd_r;
        end
      end
      // start on second strobe rise, store pins as driven
      if (!we_q && we_n && !ce_n) begin
        if (busy_r) wr_err <= wr_err + 1;
        else if (phase_r == 2'd0)
          phase_r <= (dq_wire == PROG_CODE) ? 2'd1 : (dq_wire == ERASE_CODE) ? 2'd2 : 2'd0;
        else begin
          busy_r <= (phase_r == 2'd1) || (dq_wire == ERASE_CONFIRM);
          ers_r <= (phase_r == 2'd2);
          wa_r <= addr[7:0];
          wd_r <= dq_wire;
          left_r <= busy_cyc;
          phase_r <= 2'd0;
        end
      end
    end
  end

  // status byte; low six lines float as noise
  assign dq_en  = !ce_n && !oe_n;
  assign dq_drv = busy_r ? {ers_r ? 1'b0 : ~wd_r[7], tog_r, flt_r} : mem[addr[7:0]];
endmodule : faps_flash_model

// ==== bench/flash_auto_program_erase_status_tb.sv ====
// Self-checking bench for the flash program/erase host sequencer.
// Assumes the behavioural flash model answers on the far side of the pins.
module flash_auto_program_erase_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst, cmd_valid, cmd_erase, cmd_ready, done, fail, busy;
  logic        ce_n, oe_n, we_n, vpp_hi, dq_oe, dq_en, hang;
  logic [15:0] cmd_addr, addr, busy_cyc;
  logic [7:0]  cmd_data, last_status, dq_i, dq_o, dq_drv, flt_pat, s1;
  int          errors, comparisons;

  // ----------------------------------------
  // Clock, wire and instances
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Undriven wire shows a moving pattern, never a stale value
  always @(posedge ref_clk) flt_pat <= ~flt_pat;
  assign dq_i = dq_oe ? dq_o : (dq_en ? dq_drv : flt_pat);

  faps_host #(.PROG_TMO_CYC(2000), .ERASE_TMO_CYC(5000)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_erase(cmd_erase), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .done(done), .fail(fail), .busy(busy),
    .last_status(last_status), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .vpp_hi(vpp_hi), .addr(addr),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
  faps_flash_model u_flash (
    .ref_clk(ref_clk), .rst(rst), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .vpp_hi(vpp_hi), .addr(addr),
    .dq_wire(dq_i), .hang(hang), .busy_cyc(busy_cyc), .dq_drv(dq_drv), .dq_en(dq_en));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Bounded wait for a pin level; a limit that runs out ends the run
  task automatic wait_pin(ref logic sig, input logic lvl, input int lim);
    int n;
    n = 0;
    while (sig !== lvl && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    if (sig !== lvl) begin
      errors++;
      $display("mismatch wait_limit expected %h seen %h", lvl, sig);
      give_verdict();
    end
  endtask : wait_pin

  task automatic do_cmd(input logic ers, input logic [15:0] a, input logic [7:0] d);
    wait_pin(cmd_ready, 1'b1, 100);
    cmd_erase = ers;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask : do_cmd

  // One whole status read, then time for the result to land
  task automatic wait_read();
    wait_pin(oe_n, 1'b0, 500);
    wait_pin(oe_n, 1'b1, 100);
    repeat (2) @(negedge ref_clk);
  endtask : wait_read

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_prog_fast();
    busy_cyc = 16'd100;
    do_cmd(1'b0, 16'h0012, 8'h5a);
    wait_pin(done, 1'b1, 3000);
    check("prog_fail", 8'h00, {7'h0, fail});
    check("prog_status", 8'ha5, last_status);
    check("cell_written", 8'ha5, u_flash.mem[8'h12]);
    check("cell_neighbour", 8'hff, u_flash.mem[8'h13]);
    // Done stands one cycle, then the port is free again
    @(negedge ref_clk);
    check("done_pulse", 8'h01, {5'h0, done, busy, cmd_ready});
    $display("test prog_fast done");
  endtask : t_prog_fast

  task automatic t_prog_slow();
    busy_cyc = 16'd1500;
    do_cmd(1'b0, 16'h0040, 8'h3c);
    wait_read();
    s1 = last_status;
    check("busy_poll", 8'h00, {7'h0, s1[7]});
    check("busy_level", 8'h02, {6'h0, busy, cmd_ready});
    // A request while busy must be ignored
    cmd_addr = 16'h0050;
    cmd_data = 8'h00;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    wait_read();
    check("toggle_flip", 8'h01, {7'h0, s1[6] ^ last_status[6]});
    wait_pin(done, 1'b1, 3000);
    check("slow_fail", 8'h00, {7'h0, fail});
    check("slow_status", 8'hc3, last_status);
    check("refused_cell", 8'hff, u_flash.mem[8'h50]);
    $display("test prog_slow done");
  endtask : t_prog_slow

  task automatic t_erase();
    busy_cyc = 16'd3000;
    do_cmd(1'b1, 16'h0000, 8'h00);
    wait_read();
    check("erase_poll", 8'h00, {7'h0, last_status[7]});
    wait_pin(done, 1'b1, 6000);
    check("erase_fail", 8'h00, {7'h0, fail});
    check("erase_status", 8'hff, last_status);
    for (int i = 0; i < 256; i++) check("erased_cell", 8'hff, u_flash.mem[i]);
    $display("test erase done");
  endtask : t_erase

  task automatic t_timeout();
    hang = 1'b1;
    busy_cyc = 16'd100;
    do_cmd(1'b0, 16'h0001, 8'h00);
    wait_pin(done, 1'b1, 2600);
    check("tmo_fail", 8'h01, {7'h0, fail});
    hang = 1'b0;
    // Let the stuck device finish before the next command
    repeat (200) @(negedge ref_clk);
    do_cmd(1'b0, 16'h0002, 8'hf0);
    check("fail_cleared", 8'h00, {7'h0, fail});
    wait_pin(done, 1'b1, 3000);
    check("retry_status", 8'h0f, last_status);
    $display("test timeout done");
  endtask : t_timeout

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, cmd_valid, cmd_erase, hang} = 4'h8;
    cmd_addr = 16'h0;
    cmd_data = 8'h0;
    busy_cyc = 16'd100;
    flt_pat = 8'h55;
    errors = 0;
    comparisons = 0;
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    check("idle_pins", 8'he0, {ce_n, oe_n, we_n, vpp_hi, dq_oe, busy, fail, done});
    t_prog_fast();
    t_prog_slow();
    t_erase();
    t_timeout();
    check("vpp_moves", 8'h00, 8'(u_flash.vpp_err));
    check("write_busy", 8'h00, 8'(u_flash.wr_err));
    give_verdict();
  end
endmodule : flash_auto_program_erase_status_tb

// ==== design/faps_host.sv ====
// Host sequencer that drives a flash's program/erase pins and polls status.
// Assumes the flash pins are wired directly; dq_i is asynchronous.
`include "faps_map.svh"
module faps_host #(
  parameter int          AW            = 16,
  parameter int unsigned PROG_TMO_CYC  = `FAPS_PROG_TMO_CYC,
  parameter int unsigned ERASE_TMO_CYC = `FAPS_ERASE_TMO_CYC,
  parameter logic [7:0]  PROG_CODE     = 8'h01,
  parameter logic [7:0]  ERASE_CODE    = 8'h02,
  parameter logic [7:0]  ERASE_CONFIRM = 8'h03
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          cmd_valid,
  input  wire logic          cmd_erase,
  input  wire logic [AW-1:0] cmd_addr,
  input  wire logic [7:0]    cmd_data,
  output logic               cmd_ready,
  output logic               done,
  output logic               fail,
  output logic               busy,
  output logic [7:0]         last_status,
  output logic               ce_n,
  output logic               oe_n,
  output logic               we_n,
  output logic               vpp_hi,
  output logic [AW-1:0]      addr,
  input  wire logic [7:0]    dq_i,
  output logic [7:0]         dq_o,
  output logic               dq_oe
);

  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam logic [7:0] C_VPS  = 8'(`FAPS_CYC(`FAPS_T_VPS_NS));
  localparam logic [7:0] C_CESC = 8'(`FAPS_CYC(`FAPS_T_CESC_NS));
  localparam logic [7:0] C_CEP  = 8'(`FAPS_CYC(`FAPS_T_CEP_NS));
  localparam logic [7:0] C_GAP1 = 8'(`FAPS_CYC(`FAPS_T_CWC_NS - `FAPS_T_CEP_NS));
  localparam logic [7:0] C_CEPH = 8'(`FAPS_CYC(`FAPS_T_CEPH2_NS));
  localparam logic [7:0] C_CESP = 8'(`FAPS_CYC(`FAPS_T_CESP_NS));
  localparam logic [7:0] C_RD   = 8'(`FAPS_CYC(`FAPS_T_DPA_NS) + `FAPS_SYNC_LAT);
  localparam logic [7:0] C_DF   = 8'(`FAPS_CYC(`FAPS_T_DF_NS));
  localparam logic [7:0] C_OES  = 8'(`FAPS_CYC(`FAPS_T_OES_NS));
  localparam logic [7:0] C_VPH  = 8'(`FAPS_CYC(`FAPS_T_VPH_NS));

  // ----------------------------------------
  // State
  // ----------------------------------------
  faps_pkg::faps_state_t st_r, st_nxt;
  logic [7:0]    cnt_r, cnt_nxt;
  logic [31:0]   tmo_r, tmo_nxt, lim_r, lim_nxt;
  logic          rdy_r, rdy_nxt, done_r, done_nxt, fail_r, fail_nxt;
  logic          busy_r, busy_nxt, ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt;
  logic          we_n_r, we_n_nxt, vpp_r, vpp_nxt, dq_oe_r, dq_oe_nxt;
  logic          erase_r, erase_nxt, wr2_r, wr2_nxt, armed_r, armed_nxt;
  logic          exp_r, exp_nxt, prev_r, prev_nxt, have_r, have_nxt;
  logic [7:0]    data_r, data_nxt, dq_o_r, dq_o_nxt, stat_r, stat_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [7:0]    dq_s;
  logic          polling;

  // Pins from the flash are asynchronous to ref_clk
  faps_sync #(
    .W (8)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (dq_i),
    .dout    (dq_s)
  );

  assign polling = (st_r == faps_pkg::S_POLL_RD) || (st_r == faps_pkg::S_POLL_EVAL)
                || (st_r == faps_pkg::S_POLL_GAP) || (st_r == faps_pkg::S_POLL_CE);

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = (cnt_r == 8'h00) ? 8'h00 : cnt_r - 8'h01;
    tmo_nxt = tmo_r;
    lim_nxt = lim_r;
    rdy_nxt = rdy_r;
    done_nxt = 1'b0;
    fail_nxt = fail_r;
    busy_nxt = busy_r;
    ce_n_nxt = ce_n_r;
    oe_n_nxt = oe_n_r;
    we_n_nxt = we_n_r;
    vpp_nxt = vpp_r;
    dq_oe_nxt = dq_oe_r;
    dq_o_nxt = dq_o_r;
    erase_nxt = erase_r;
    wr2_nxt = wr2_r;
    armed_nxt = armed_r;
    exp_nxt = exp_r;
    prev_nxt = prev_r;
    have_nxt = have_r;
    data_nxt = data_r;
    stat_nxt = stat_r;
    addr_nxt = addr_r;
    unique case (st_r)
      faps_pkg::S_IDLE: begin
        rdy_nxt = 1'b1;
        if (cmd_valid && rdy_r) begin
          rdy_nxt = 1'b0;
          busy_nxt = 1'b1;
          fail_nxt = 1'b0;
          erase_nxt = cmd_erase;
          data_nxt = cmd_data;
          addr_nxt = cmd_addr;
          wr2_nxt = 1'b0;
          armed_nxt = 1'b0;
          have_nxt = 1'b0;
          exp_nxt = cmd_erase ? 1'b1 : ~cmd_data[`FAPS_POLL_BIT];
          lim_nxt = cmd_erase ? ERASE_TMO_CYC : PROG_TMO_CYC;
          // supply rises while both selects high
          vpp_nxt = 1'b1;
          cnt_nxt = C_VPS;
          st_nxt = faps_pkg::S_VPP_UP;
        end
      end
      faps_pkg::S_VPP_UP: begin
        if (cnt_r == 8'h00) begin
          ce_n_nxt = 1'b0;
          dq_oe_nxt = 1'b1;
          dq_o_nxt = erase_r ? ERASE_CODE : PROG_CODE;
          cnt_nxt = C_CESC;
          st_nxt = faps_pkg::S_WR_SETUP;
        end
      end
      faps_pkg::S_WR_SETUP: begin
        if (cnt_r == 8'h00) begin
          we_n_nxt = 1'b0;
          cnt_nxt = C_CEP;
          st_nxt = faps_pkg::S_WE_LOW;
        end
      end
      faps_pkg::S_WE_LOW: begin
        if (cnt_r == 8'h00) begin
          we_n_nxt = 1'b1;
          cnt_nxt = wr2_r ? C_CEPH : C_GAP1;
          st_nxt = faps_pkg::S_WE_HIGH;
        end
      end
      faps_pkg::S_WE_HIGH: begin
        if (cnt_r == 8'h00 && !wr2_r) begin
          wr2_nxt = 1'b1;
          dq_o_nxt = erase_r ? ERASE_CONFIRM : ~data_r;
          we_n_nxt = 1'b0;
          cnt_nxt = C_CEP;
          st_nxt = faps_pkg::S_WE_LOW;
        end else if (cnt_r == 8'h00) begin
          // status reads only after second strobe
          dq_oe_nxt = 1'b0;
          armed_nxt = 1'b1;
          tmo_nxt = 32'h0;
          cnt_nxt = C_CESP;
          st_nxt = faps_pkg::S_POLL_CE;
        end
      end
      faps_pkg::S_POLL_CE, faps_pkg::S_POLL_GAP: begin
        if (cnt_r == 8'h00) begin
          oe_n_nxt = 1'b0;
          cnt_nxt = C_RD;
          st_nxt = faps_pkg::S_POLL_RD;
        end
      end
      faps_pkg::S_POLL_RD: begin
        if (cnt_r == 8'h00) begin
          st_nxt = faps_pkg::S_POLL_EVAL;
        end
      end
      faps_pkg::S_POLL_EVAL: begin
        stat_nxt = dq_s;
        oe_n_nxt = 1'b1;
        prev_nxt = dq_s[`FAPS_TOGGLE_BIT];
        have_nxt = 1'b1;
        // done when toggle still and polling true
        if (have_r && dq_s[`FAPS_TOGGLE_BIT] == prev_r && dq_s[`FAPS_POLL_BIT] == exp_r) begin
          cnt_nxt = C_OES;
          st_nxt = faps_pkg::S_CE_OFF;
        end else begin
          cnt_nxt = C_DF;
          st_nxt = faps_pkg::S_POLL_GAP;
        end
      end
      faps_pkg::S_CE_OFF: begin
        if (cnt_r == 8'h00) begin
          ce_n_nxt = 1'b1;
          cnt_nxt = C_DF;
          st_nxt = faps_pkg::S_VPP_DN;
        end
      end
      faps_pkg::S_VPP_DN: begin
        // supply falls with both selects high
        if (cnt_r == 8'h00) begin
          vpp_nxt = 1'b0;
          cnt_nxt = C_VPH;
          st_nxt = faps_pkg::S_END;
        end
      end
      faps_pkg::S_END: begin
        if (cnt_r == 8'h00) begin
          done_nxt = 1'b1;
          busy_nxt = 1'b0;
          st_nxt = faps_pkg::S_IDLE;
        end
      end
      default: begin
        st_nxt = faps_pkg::S_IDLE;
      end
    endcase
    if (polling) begin
      tmo_nxt = tmo_r + 32'h1;
    end
    if (polling && tmo_r >= lim_r) begin
      fail_nxt = 1'b1;
      oe_n_nxt = 1'b1;
      cnt_nxt = C_OES;
      st_nxt = faps_pkg::S_CE_OFF;
    end
  end

  // Register everything; pins idle deselected with supply low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= faps_pkg::S_IDLE;
      cnt_r <= 8'h00;
      tmo_r <= 32'h0;
      lim_r <= 32'h0;
      rdy_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      busy_r <= 1'b0;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      vpp_r <= 1'b0;
      dq_oe_r <= 1'b0;
      dq_o_r <= 8'h00;
      erase_r <= 1'b0;
      wr2_r <= 1'b0;
      armed_r <= 1'b0;
      exp_r <= 1'b0;
      prev_r <= 1'b0;
      have_r <= 1'b0;
      data_r <= 8'h00;
      stat_r <= 8'h00;
      addr_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      tmo_r <= tmo_nxt;
      lim_r <= lim_nxt;
      rdy_r <= rdy_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      busy_r <= busy_nxt;
      ce_n_r <= ce_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
      vpp_r <= vpp_nxt;
      dq_oe_r <= dq_oe_nxt;
      dq_o_r <= dq_o_nxt;
      erase_r <= erase_nxt;
      wr2_r <= wr2_nxt;
      armed_r <= armed_nxt;
      exp_r <= exp_nxt;
      prev_r <= prev_nxt;
      have_r <= have_nxt;
      data_r <= data_nxt;
      stat_r <= stat_nxt;
      addr_r <= addr_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cmd_ready = rdy_r;
  assign done = done_r;
  assign fail = fail_r;
  assign busy = busy_r;
  assign last_status = stat_r;
  assign ce_n = ce_n_r;
  assign oe_n = oe_n_r;
  assign we_n = we_n_r;
  assign vpp_hi = vpp_r;
  assign addr = addr_r;
  assign dq_o = dq_o_r;
  assign dq_oe = dq_oe_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_vpp_safe;
    $changed(vpp_r) |-> ce_n_r && oe_n_r && $past(ce_n_r) && $past(oe_n_r);
  endproperty
  a_vpp_safe: assert property (p_vpp_safe) else $error("supply moved while selected");

  property p_inv_data;
    (st_r == faps_pkg::S_WE_LOW && wr2_r && !erase_r) |-> dq_o_r == ~data_r;
  endproperty
  a_inv_data: assert property (p_inv_data) else $error("program data not inverted");

  property p_poll_armed;
    $fell(oe_n_r) |-> armed_r && we_n_r && !dq_oe_r;
  endproperty
  a_poll_armed: assert property (p_poll_armed) else $error("read before second strobe");

  property p_no_cmd_busy;
    busy_r |-> !rdy_r;
  endproperty
  a_no_cmd_busy: assert property (p_no_cmd_busy) else $error("ready while busy");

  property p_tmo_fail;
    (polling && tmo_r >= lim_r) |=> fail_r && st_r == faps_pkg::S_CE_OFF;
  endproperty
  a_tmo_fail: assert property (p_tmo_fail) else $error("timeout not flagged");

  property p_done_ok;
    ($rose(done_r) && !fail_r) |-> stat_r[`FAPS_POLL_BIT] == exp_r && have_r;
  endproperty
  a_done_ok: assert property (p_done_ok) else $error("done without valid status");

  property p_prog_lim;
    ($rose(busy_r) && !erase_r) |-> lim_r == PROG_TMO_CYC;
  endproperty
  a_prog_lim: assert property (p_prog_lim) else $error("program timeout not loaded");

  property p_erase_lim;
    ($rose(busy_r) && erase_r) |-> lim_r == ERASE_TMO_CYC;
  endproperty
  a_erase_lim: assert property (p_erase_lim) else $error("erase timeout not loaded");

  property p_no_clash;
    !(dq_oe_r && !oe_n_r);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("bus contention");

  c_prog_ok: cover property ($rose(done_r) && !fail_r && !erase_r);
  c_erase_ok: cover property ($rose(done_r) && !fail_r && erase_r);
  c_timeout: cover property ($rose(fail_r));

endmodule : faps_host

// ==== design/faps_map.svh ====
// Timing constants of the flash program/erase host sequencer.
// Assumes a single 200 MHz clock; all counts are derived from it.
`ifndef FAPS_MAP_SVH
`define FAPS_MAP_SVH

// ----------------------------------------
// Clock and conversion
// ----------------------------------------
`define FAPS_CLK_MHZ        200
// Least times round up to whole cycles
`define FAPS_CYC(ns)        ((((ns) * `FAPS_CLK_MHZ) + 999) / 1000)

// ----------------------------------------
// Pin timing, in ns
// ----------------------------------------
`define FAPS_T_VPS_NS       100
`define FAPS_T_OES_NS       100
`define FAPS_T_CWC_NS       150
`define FAPS_T_CEP_NS       60
`define FAPS_T_CEPH2_NS     100
`define FAPS_T_CESP_NS      100
`define FAPS_T_CESC_NS      100
`define FAPS_T_VPH_NS       100
`define FAPS_T_DF_NS        35
`define FAPS_T_DPA_NS       150

// ----------------------------------------
// Operation times and timeouts
// ----------------------------------------
`define FAPS_T_AVT_MAX_US   300
`define FAPS_T_AETC_TYP_S   5
`define FAPS_PROG_TMO_CYC   (`FAPS_T_AVT_MAX_US * `FAPS_CLK_MHZ)
`define FAPS_ERASE_TYP_CYC  (`FAPS_T_AETC_TYP_S * `FAPS_CLK_MHZ * 1000000)
`define FAPS_ERASE_TMO_CYC  (2 * `FAPS_ERASE_TYP_CYC)

// ----------------------------------------
// Status bit positions and sampling
// ----------------------------------------
`define FAPS_POLL_BIT       7
`define FAPS_TOGGLE_BIT     6
`define FAPS_SYNC_LAT       4

`endif

// ==== design/faps_pkg.sv ====
// Types shared by the flash program/erase host sequencer.
// Assumes nothing of its surroundings.
package faps_pkg;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    S_IDLE      = 4'h0,
    S_VPP_UP    = 4'h1,
    S_WR_SETUP  = 4'h2,
    S_WE_LOW    = 4'h3,
    S_WE_HIGH   = 4'h4,
    S_POLL_CE   = 4'h5,
    S_POLL_RD   = 4'h6,
    S_POLL_EVAL = 4'h7,
    S_POLL_GAP  = 4'h8,
    S_CE_OFF    = 4'h9,
    S_VPP_DN    = 4'ha,
    S_END       = 4'hb
  } faps_state_t;

endpackage : faps_pkg

// ==== design/faps_sync.sv ====
// Three-stage input synchroniser for the flash data pins.
// Assumes asynchronous inputs; output changes once stages two and three agree.
module faps_sync #(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_r, s2_r, s3_r, dout_r;
  logic [W-1:0] dout_nxt;

  // Accept a bit only when it has held for two samples
  always_comb begin
    dout_nxt = dout_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        dout_nxt[i] = s3_r[i];
      end
    end
  end

  // Stage one feeds stage two only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      dout_r <= '0;
    end else begin
      s1_r   <= din;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      dout_r <= dout_nxt;
    end
  end

  assign dout = dout_r;

endmodule : faps_sync
